// ### rtl/eeel_consts.vh
`ifndef EEEL_CONSTS_VH
`define EEEL_CONSTS_VH
`define EEEL_LINES        16
`define EEEL_SRCS         17
`define EEEL_MON_LINE     16
`define EEEL_OFF_ENABLE   12'h000
`define EEEL_OFF_RISE     12'h004
`define EEEL_OFF_FALL     12'h008
`define EEEL_OFF_PENDING  12'h00c
`define EEEL_OFF_EVENT    12'h010
`define EEEL_OFF_SWTRIG   12'h014
`define EEEL_OFF_STATUS   12'h018
`define EEEL_OFF_ROUTE0   12'h020
`define EEEL_ROUTE_REGS   4
`define EEEL_ROUTE_W      4
`define EEEL_PORTS        4
`define EEEL_RST_MASK     17'h00000
`define EEEL_ST_STOP      0
`define EEEL_ST_WAKE      1
`endif

// ### rtl/eeel_capture.v
`include "eeel_consts.vh"
module eeel_capture (
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // raw source and edge selection
    input  wire        line_in,
    input  wire        rise_en,
    input  wire        fall_en,
    // detected edge, synchronised, and unsynchronised capture flag
    output reg         edge_seen,
    output wire        async_flag
);
    reg  tog_rise;
    reg  tog_fall;
    reg  rise_a;
    reg  rise_b;
    reg  rise_c;
    reg  fall_a;
    reg  fall_b;
    reg  fall_c;

    // high from a selected edge until it has passed the synchroniser
    assign async_flag = (tog_rise ^ rise_c) | (tog_fall ^ fall_c);

    // clockless capture: each selected edge flips a toggle, no clear
    // so an edge can never be lost against an acknowledge
    always @(posedge line_in or negedge presetn) begin
        if (!presetn)
            tog_rise <= 1'b0;
        else if (rise_en)
            tog_rise <= ~tog_rise;
    end

    always @(negedge line_in or negedge presetn) begin
        if (!presetn)
            tog_fall <= 1'b0;
        else if (fall_en)
            tog_fall <= ~tog_fall;
    end

    // two-stage synchronisers, third stage detects a change
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rise_a    <= 1'b0;
            rise_b    <= 1'b0;
            rise_c    <= 1'b0;
            fall_a    <= 1'b0;
            fall_b    <= 1'b0;
            fall_c    <= 1'b0;
            edge_seen <= 1'b0;
        end else begin
            rise_a    <= tog_rise;
            rise_b    <= rise_a;
            rise_c    <= rise_b;
            fall_a    <= tog_fall;
            fall_b    <= fall_a;
            fall_c    <= fall_b;
            edge_seen <= (rise_b ^ rise_c) | (fall_b ^ fall_c);
        end
    end
endmodule // eeel_capture

// ### rtl/eeel_top.v
// Decided for this implementation: the APB register port and the address map.
`include "eeel_consts.vh"
module eeel_top (
    // apb
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // sources
    input  wire [63:0] port_pins,
    input  wire        programmable_voltage_monitor,
    input  wire        stop_mode,
    // to the core
    output reg  [16:0] irq_lines,
    output reg  [16:0] event_pulse,
    output reg         stop_wakeup
);
    reg  [16:0] enable_mask;
    reg  [16:0] event_mask;
    reg  [16:0] rise_sel;
    reg  [16:0] fall_sel;
    reg  [16:0] pending;
    reg  [63:0] route;
    reg  [16:0] sw_trig;
    reg  [31:0] next_prdata;
    reg         next_pready;
    reg         next_pslverr;
    reg  [15:0] io_line;
    wire [16:0] src;
    wire [16:0] edge_seen;
    wire [16:0] async_flag;
    wire        wr;
    wire        wr_ok;
    wire        rd;
    wire [16:0] set_vec;
    wire [16:0] clr_vec;
    integer     i;

    function [5:0] pin_index;
        input [3:0] port;
        input [3:0] line;
        pin_index = {port[1:0], line};
    endfunction

    function hit;
        input [11:0] addr;
        input [11:0] off;
        hit = (addr == off);
    endfunction

    function mapped;
        input [11:0] addr;
        mapped = (addr[1:0] == 2'b00) &&
                 ((addr <= `EEEL_OFF_STATUS) ||
                  (addr >= `EEEL_OFF_ROUTE0 && addr <= 12'h02c));
    endfunction

    // route selects pin of chosen port onto each line
    always @* begin
        io_line = 16'h0000;
        for (i = 0; i < `EEEL_LINES; i = i + 1)
            io_line[i] = port_pins[pin_index(route[i*4 +: 4], i[3:0])];
    end

    assign src = {programmable_voltage_monitor, io_line};

    assign wr = psel & penable & pwrite & pready;
    assign rd = psel & ~penable & ~pwrite;
    assign wr_ok = wr & ~pslverr;

    genvar g;
    generate
        for (g = 0; g < `EEEL_SRCS; g = g + 1) begin : gl
            eeel_capture u_cap (
                .pclk      (pclk),
                .presetn   (presetn),
                .line_in   (src[g]),
                .rise_en   (rise_sel[g]),
                .fall_en   (fall_sel[g]),
                .edge_seen (edge_seen[g]),
                .async_flag(async_flag[g])
            );
        end
    endgenerate

    assign set_vec = (edge_seen | sw_trig) & enable_mask;
    assign clr_vec = (wr && hit(paddr, `EEEL_OFF_PENDING)) ?
                     pwdata[16:0] : 17'h00000;

    always @* begin
        next_prdata = 32'h00000000;
        case (paddr)
            `EEEL_OFF_ENABLE:  next_prdata = {15'h0000, enable_mask};
            `EEEL_OFF_RISE:    next_prdata = {15'h0000, rise_sel};
            `EEEL_OFF_FALL:    next_prdata = {15'h0000, fall_sel};
            `EEEL_OFF_PENDING: next_prdata = {15'h0000, pending};
            `EEEL_OFF_EVENT:   next_prdata = {15'h0000, event_mask};
            `EEEL_OFF_STATUS:  next_prdata = {30'h00000000,
                                   stop_wakeup, stop_mode};
            12'h020:           next_prdata = {16'h0000, route[15:0]};
            12'h024:           next_prdata = {16'h0000, route[31:16]};
            12'h028:           next_prdata = {16'h0000, route[47:32]};
            12'h02c:           next_prdata = {16'h0000, route[63:48]};
            default:           next_prdata = 32'h00000000;
        endcase
    end

    // bus answer for the access phase
    always @* begin
        next_pready  = psel & ~penable;
        next_pslverr = psel & ~penable & ~mapped(paddr);
    end

    // apb slave, no wait states, unmapped answers with pslverr
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= next_pready;
            pslverr <= next_pslverr;
            if (rd)
                prdata <= next_prdata;
        end
    end

    // line enables
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            enable_mask <= `EEEL_RST_MASK;
        else if (wr_ok && hit(paddr, `EEEL_OFF_ENABLE))
            enable_mask <= pwdata[16:0];
    end

    // event enables
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            event_mask <= `EEEL_RST_MASK;
        else if (wr_ok && hit(paddr, `EEEL_OFF_EVENT))
            event_mask <= pwdata[16:0];
    end

    // rising edge select
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            rise_sel <= 17'h00000;
        else if (wr_ok && hit(paddr, `EEEL_OFF_RISE))
            rise_sel <= pwdata[16:0];
    end

    // falling edge select
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            fall_sel <= 17'h00000;
        else if (wr_ok && hit(paddr, `EEEL_OFF_FALL))
            fall_sel <= pwdata[16:0];
    end

    // route fields, four lines per word
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            route <= 64'h0000000000000000;
        end else if (wr_ok) begin
            case (paddr)
                12'h020: route[15:0]  <= pwdata[15:0];
                12'h024: route[31:16] <= pwdata[15:0];
                12'h028: route[47:32] <= pwdata[15:0];
                12'h02c: route[63:48] <= pwdata[15:0];
                default: route        <= route;
            endcase
        end
    end

    // software trigger, one-cycle pulse per written one
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            sw_trig <= 17'h00000;
        else if (wr_ok && hit(paddr, `EEEL_OFF_SWTRIG))
            sw_trig <= pwdata[16:0];
        else
            sw_trig <= 17'h00000;
    end

    // pending: set wins over write-one clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            pending <= 17'h00000;
        else
            pending <= (pending & ~clr_vec) | set_vec;
    end

    // interrupt level mirrors the next pending value
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            irq_lines <= 17'h00000;
        else
            irq_lines <= (pending & ~clr_vec) | set_vec;
    end

    // one pulse per cycle with a detected edge or software trigger
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            event_pulse <= 17'h00000;
        else
            event_pulse <= (edge_seen | sw_trig) & event_mask;
    end

    // wake while stopped, from captures not yet synchronised
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            stop_wakeup <= 1'b0;
        else
            stop_wakeup <= stop_mode &
                           |(async_flag & (enable_mask | event_mask));
    end
endmodule // eeel_top

// ### bench/eeel_pin_model.sv
module eeel_pin_model (
    // toggle request, bit 6 asks for a glitch shorter than pclk
    input  wire logic       go,
    input  wire logic [6:0] idx,
    output logic     [63:0] pins
);
    timeunit 1ns / 1ps;
    initial pins = 64'h0;
    always @(go) begin
        #2 pins[idx[5:0]] = ~pins[idx[5:0]];
        if (idx[6]) #4 pins[idx[5:0]] = ~pins[idx[5:0]];
    end
endmodule // eeel_pin_model

// ### bench/eeel_monitor.sv
module eeel_monitor (
    // clock and reset
    input wire        pclk,
    input wire        presetn,
    // apb
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    // sources and outputs
    input wire        stop_mode,
    input wire        stop_wakeup,
    input wire [16:0] irq_lines,
    input wire [16:0] event_pulse
);
    timeunit 1ns / 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_answer; psel && !penable |=> pready; endproperty
    a_answer: assert property (p_answer) else $error("no pready");
    property p_single; pready |=> !pready; endproperty
    a_single: assert property (p_single) else $error("long pready");
    property p_cause; pready |-> $past(psel && !penable); endproperty
    a_cause: assert property (p_cause) else $error("stray pready");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("lone pslverr");
    property p_unmap;
        psel && !penable && paddr == 12'hffc |=> pslverr;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped ok");
    property p_sticky; !(penable && pwrite && paddr == 12'h00c)
        |=> (irq_lines & $past(irq_lines)) == $past(irq_lines); endproperty
    a_sticky: assert property (p_sticky) else $error("irq dropped");
    property p_pulse; (event_pulse & $past(event_pulse)) == 17'h0; endproperty
    a_pulse: assert property (p_pulse) else $error("long event");
    property p_wake; stop_wakeup |-> $past(stop_mode); endproperty
    a_wake: assert property (p_wake) else $error("wake not stopped");
    c_irq: cover property (|irq_lines);
    c_err: cover property (pslverr);
    c_wake: cover property (stop_wakeup);
endmodule // eeel_monitor
bind eeel_top eeel_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
    .stop_mode(stop_mode), .stop_wakeup(stop_wakeup), .paddr(paddr),
    .prdata(prdata), .irq_lines(irq_lines), .event_pulse(event_pulse));

// ### bench/tb.sv
module tb;
    timeunit 1ns / 1ps;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        pvm = 0, stop_mode = 0, go = 0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd, rw [4];
    logic [6:0]  idx = 7'h00;
    wire  [31:0] prdata;
    wire  [63:0] pins;
    wire  [16:0] irq, ev;
    wire         pready, pslverr, wake;
    int          num_errors = 0, tests_run = 0, l, m, en, p, e, i, t;
    int          ev_cnt = 0, c0;
    always #10 pclk = ~pclk;
    always @(posedge pclk) ev_cnt <= ev_cnt + $countones(ev);
    eeel_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .pwrite(pwrite), .penable(penable), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port_pins(pins), .stop_mode(stop_mode),
        .programmable_voltage_monitor(pvm), .irq_lines(irq),
        .event_pulse(ev), .stop_wakeup(wake));
    eeel_pin_model PM (.go(go), .idx(idx), .pins(pins));
    task end_sim(int bad);
        num_errors += bad;
        if (num_errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk(string n, logic [31:0] x, logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, x, g);
        end
    endtask
    task apb(logic wr, logic [11:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        for (t = 0; t < 20 && pready !== 1'b1; t++) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        if (pready !== 1'b1) end_sim(1);
    endtask
    initial begin
        void'($urandom(32'h1147599b));
        repeat (20) @(posedge pclk);
        presetn <= 1;
        apb(0, 12'hffc, 0);
        chk("slverr", 1, {31'h0, err});
        chk("slverr data", 0, rd);
        for (i = 0; i < 4; i++) begin
            rw[i] = $urandom & 32'h3333;
            apb(1, 12'h020 + 12'(4 * i), rw[i]);
        end
        for (i = 0; i < 40; i++) begin
            l = $urandom % 16;
            m = 1 + i % 3;
            en = i % 5 != 4;
            p = ((rw[l / 4] >> (l % 4 * 4)) & 3) * 16 + l;
            apb(1, 12'h000, en << l);
            apb(1, 12'h010, en << l);
            apb(1, 12'h004, (m & 1) << l);
            apb(1, 12'h008, (m >> 1) << l);
            e = en & (i % 7 == 6 | (pins[p] ? m >> 1 : m)) & 1;
            c0 = ev_cnt;
            idx <= {i % 7 == 6, p[5:0]};
            go <= ~go;
            repeat (8) @(posedge pclk);
            apb(0, 12'h00c, 0);
            chk("pending", e << l, rd);
            chk("irq", e << l, {15'h0, irq});
            chk("event", e, ev_cnt - c0);
            apb(1, 12'h00c, 1 << l);
        end
        apb(1, 12'h000, 32'h8);
        apb(1, 12'h010, 32'h8);
        c0 = ev_cnt;
        apb(1, 12'h014, 32'h8);
        repeat (2) @(posedge pclk);
        apb(0, 12'h00c, 0);
        chk("sw pending", 32'h8, rd);
        chk("sw event", 1, ev_cnt - c0);
        apb(1, 12'h00c, 32'h8);
        stop_mode <= 1;
        apb(1, 12'h000, 32'h10000);
        apb(1, 12'h004, 32'h10000);
        pvm <= 1;
        repeat (2) @(posedge pclk);
        chk("wakeup", 1, {31'h0, wake});
        repeat (6) @(posedge pclk);
        apb(0, 12'h00c, 0);
        chk("monitor pending", 32'h10000, rd);
        end_sim(0);
    end
endmodule // tb
